// >>> core/psc_pkg.sv
// Package for the panel supply configuration register bank.
// Assumes a 25 MHz system clock and an APB register bus of 32-bit words.
package psc_pkg;
  // Printed offsets are register indices; byte address is four times each
  localparam logic [7:0]  IDX_GENERAL_CFG  = 8'h07;
  localparam logic [7:0]  IDX_SEQ_DELAY    = 8'h08;
  localparam logic [7:0]  IDX_ROOM_LEVEL   = 8'h09;
  localparam logic [7:0]  IDX_SEQ_LOWDELTA = 8'h0a;
  localparam logic [7:0]  IDX_HOT1_DELTA   = 8'h0b;
  localparam logic [7:0]  IDX_LOW_BREAK    = 8'h0e;
  localparam logic [7:0]  IDX_STATUS       = 8'h20;
  // Reset values
  localparam logic [7:0]  RST_GENERAL_CFG  = 8'h04;
  localparam logic [7:0]  RST_SEQ_DELAY    = 8'ha8;
  localparam logic [7:0]  RST_ROOM_LEVEL   = 8'h00;
  localparam logic [7:0]  RST_SEQ_LOWDELTA = 8'h40;
  localparam logic [4:0]  RST_HOT1_DELTA   = 5'h00;
  localparam logic [7:0]  RST_LOW_BREAK    = 8'h00;
  // Field positions, general configuration
  localparam int          B_INT_SENSOR     = 7;
  localparam int          B_REFRESH        = 6;
  localparam int          B_SPREAD         = 5;
  localparam int          B_RATE_SEL       = 4;
  localparam int          F_RETRY_LO       = 2;
  localparam int          F_FDELAY_LO      = 0;
  // Field positions, sequence delay register; F_SEQ_LO is in the sequence low delta register
  localparam int          F_GAP1_LO        = 6;
  localparam int          F_GAP2_LO        = 4;
  localparam int          F_GAP3_LO        = 2;
  localparam int          B_COMP_EN        = 1;
  localparam int          B_ROOM_LSB       = 0;
  localparam int          F_SEQ_LO         = 5;
  // Timing
  localparam longint      CLK_HZ           = 25000000;
  localparam longint      REFRESH_MS       = 1000;
  localparam longint      STEP_MS          = 5;
  localparam longint      RETRY_SHORT_MS   = 950;
  localparam longint      RETRY_LONG_MS    = 1900;
  localparam longint      FDELAY0_MS       = 15;
  localparam longint      FDELAY1_MS       = 30;
  localparam longint      FDELAY2_MS       = 60;
  localparam longint      FDELAY3_MS       = 90;
  localparam longint      REFRESH_CYC      = CLK_HZ * REFRESH_MS / 1000;
  localparam longint      STEP_CYC         = CLK_HZ * STEP_MS / 1000;
  localparam longint      RETRY_SHORT_CYC  = CLK_HZ * RETRY_SHORT_MS / 1000;
  localparam longint      RETRY_LONG_CYC   = CLK_HZ * RETRY_LONG_MS / 1000;
  localparam longint      FDELAY0_CYC      = CLK_HZ * FDELAY0_MS / 1000;
  localparam longint      FDELAY1_CYC      = CLK_HZ * FDELAY1_MS / 1000;
  localparam longint      FDELAY2_CYC      = CLK_HZ * FDELAY2_MS / 1000;
  localparam longint      FDELAY3_CYC      = CLK_HZ * FDELAY3_MS / 1000;
  localparam logic [2:0]  RETRY_LIMIT      = 3'd3;
  localparam logic [3:0]  RATE_DIV_FAST    = 4'd0;
  localparam logic [3:0]  RATE_DIV_SLOW    = 4'd4;
  localparam logic [31:0] DITHER_SEED      = 32'h1;
  localparam logic [31:0] DITHER_TAPS      = 32'h80200003;

  typedef enum logic [1:0] {
    PSC_F_IDLE  = 2'b00,
    PSC_F_QUAL  = 2'b01,
    PSC_F_WAIT  = 2'b10,
    PSC_F_STOP  = 2'b11
  } psc_fault_t;

  typedef enum logic [1:0] {
    PSC_S_IDLE  = 2'b00,
    PSC_S_GAP   = 2'b01,
    PSC_S_DONE  = 2'b10
  } psc_seq_t;
endpackage

// >>> core/psc_regs.sv
// Configuration register bank for a display power supply, with APB access,
// start-up gap timing, fault delay and retry timing, refresh request and
// the common-electrode level selection.
// Assumes a 25 MHz ref_clk, synchronous srst, and that analog status pins
// (fault, start, sensor readings) arrive asynchronously.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module psc_regs
  import psc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Analog side inputs, asynchronous
  input  wire logic [7:0]  ext_temp_code,
  input  wire logic [7:0]  int_temp_code,
  input  wire logic        fault_raw,
  input  wire logic        startup_req,
  // Controls to the analog side
  output logic             nv_reload_pulse,
  output logic             switch_clk,
  output logic             rail_restart,
  output logic [2:0]       startup_step,
  output logic [2:0]       seq_order,
  output logic [8:0]       common_level,
  output logic [7:0]       temp_used
);
  import psc_pkg::*;

  // Registers
  logic [7:0]  cfg_q;
  logic [7:0]  dly_q;
  logic [7:0]  room_q;
  logic [7:0]  seql_q;
  logic [4:0]  hot1_q;
  logic [7:0]  lowbrk_q;

  // Sensor codes are sampled bit by bit; a code caught mid-change is wrong for one cycle only
  // Synchronisers for asynchronous inputs
  logic [7:0]  ext_s1_q, ext_s2_q, int_s1_q, int_s2_q;
  logic        flt_s1_q, flt_s2_q, st_s1_q, st_s2_q, st_prev_q;

  always_ff @(posedge ref_clk) begin
    ext_s1_q <= ext_temp_code;
    ext_s2_q <= ext_s1_q;
    int_s1_q <= int_temp_code;
    int_s2_q <= int_s1_q;
    flt_s1_q <= fault_raw;
    flt_s2_q <= flt_s1_q;
    st_s1_q  <= startup_req;
    st_s2_q  <= st_s1_q;
  end

  // Word index decode used for both read and write
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
  endfunction

  logic        acc;
  logic        known;
  assign acc   = psel && penable;
  assign known = hit(paddr, IDX_GENERAL_CFG) || hit(paddr, IDX_SEQ_DELAY) ||
                 hit(paddr, IDX_ROOM_LEVEL) || hit(paddr, IDX_SEQ_LOWDELTA) ||
                 hit(paddr, IDX_HOT1_DELTA) || hit(paddr, IDX_LOW_BREAK) ||
                 hit(paddr, IDX_STATUS);

  // One wait state: pready is a register so the answer comes a cycle into access
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !known;
    end
  end

  logic        wr;
  assign wr = acc && pready && pwrite;

  // One block per register so each write path stays separate
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_q <= RST_GENERAL_CFG;
    end else if (wr && hit(paddr, IDX_GENERAL_CFG)) begin
      cfg_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dly_q <= RST_SEQ_DELAY;
    end else if (wr && hit(paddr, IDX_SEQ_DELAY)) begin
      dly_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      room_q <= RST_ROOM_LEVEL;
    end else if (wr && hit(paddr, IDX_ROOM_LEVEL)) begin
      room_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seql_q <= RST_SEQ_LOWDELTA;
    end else if (wr && hit(paddr, IDX_SEQ_LOWDELTA)) begin
      seql_q <= pwdata[7:0];
    end
  end

  // Only five bits are kept; the upper three read back as zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hot1_q <= RST_HOT1_DELTA;
    end else if (wr && hit(paddr, IDX_HOT1_DELTA)) begin
      hot1_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowbrk_q <= RST_LOW_BREAK;
    end else if (wr && hit(paddr, IDX_LOW_BREAK)) begin
      lowbrk_q <= pwdata[7:0];
    end
  end

  // Timing state
  logic [31:0] rf_cnt_q;
  logic [31:0] gap_cnt_q;
  logic [31:0] flt_cnt_q;
  logic [2:0]  tries_q;
  psc_fault_t  fst_q;
  psc_seq_t    sst_q;

  // Read mux; pready is registered so prdata is presented with it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (acc && !pready && !pwrite) begin
      prdata <= 32'h0;
      if (hit(paddr, IDX_GENERAL_CFG))  prdata[7:0] <= cfg_q;
      if (hit(paddr, IDX_SEQ_DELAY))    prdata[7:0] <= dly_q;
      if (hit(paddr, IDX_ROOM_LEVEL))   prdata[7:0] <= room_q;
      if (hit(paddr, IDX_SEQ_LOWDELTA)) prdata[7:0] <= seql_q;
      if (hit(paddr, IDX_HOT1_DELTA))   prdata[4:0] <= hot1_q;
      if (hit(paddr, IDX_LOW_BREAK))    prdata[7:0] <= lowbrk_q;
      if (hit(paddr, IDX_STATUS))       prdata[7:0] <= {fst_q, sst_q, tries_q, 1'b0};
    end
  end

  // Periodic reload request
  always_ff @(posedge ref_clk) begin
    if (srst || !cfg_q[B_REFRESH]) begin
      rf_cnt_q        <= 32'h0;
      nv_reload_pulse <= 1'b0;
    end else begin
      nv_reload_pulse <= (rf_cnt_q == 32'(REFRESH_CYC - 1));
      rf_cnt_q        <= (rf_cnt_q == 32'(REFRESH_CYC - 1)) ? 32'h0 : rf_cnt_q + 32'h1;
    end
  end

  // Switching clock: 25 MHz over 12 steps gives about 2.1 MHz, over 60 gives 420 kHz.
  // Dither stretches the half period by 0 or 1 step from an LFSR.
  logic [31:0] lfsr_q;
  logic [5:0]  sw_cnt_q;
  logic [5:0]  half_lim;
  assign half_lim = (cfg_q[B_RATE_SEL] ? 6'd29 : 6'd5) +
                    (cfg_q[B_SPREAD] ? {5'h0, lfsr_q[0]} : 6'd0);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lfsr_q     <= DITHER_SEED;
      sw_cnt_q   <= 6'd0;
      switch_clk <= 1'b0;
    end else if (sw_cnt_q >= half_lim) begin
      sw_cnt_q   <= 6'd0;
      switch_clk <= !switch_clk;
      lfsr_q     <= lfsr_q[0] ? ((lfsr_q >> 1) ^ DITHER_TAPS) : (lfsr_q >> 1);
    end else begin
      sw_cnt_q   <= sw_cnt_q + 6'd1;
    end
  end

  // Start-up gaps
  function automatic logic [31:0] gap_len(input logic [1:0] code);
    gap_len = 32'(STEP_CYC) * {30'h0, code};
  endfunction

  logic [1:0]  gap_code;
  always_comb begin
    case (startup_step)
      3'd0:    gap_code = dly_q[F_GAP1_LO +: 2];
      3'd1:    gap_code = dly_q[F_GAP2_LO +: 2];
      default: gap_code = dly_q[F_GAP3_LO +: 2];
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sst_q        <= PSC_S_IDLE;
      startup_step <= 3'd0;
      gap_cnt_q    <= 32'h0;
      st_prev_q    <= 1'b0;
      seq_order    <= 3'd0;
    end else begin
      st_prev_q <= st_s2_q;
      seq_order <= seql_q[F_SEQ_LO +: 3];
      case (sst_q)
        PSC_S_IDLE: begin
          if (st_s2_q && !st_prev_q) begin
            sst_q        <= PSC_S_GAP;
            startup_step <= 3'd0;
            gap_cnt_q    <= 32'h0;
          end
        end
        PSC_S_GAP: begin
          if (gap_cnt_q >= gap_len(gap_code)) begin
            gap_cnt_q    <= 32'h0;
            startup_step <= startup_step + 3'd1;
            if (startup_step == 3'd2) sst_q <= PSC_S_DONE;
          end else begin
            gap_cnt_q <= gap_cnt_q + 32'h1;
          end
        end
        PSC_S_DONE: begin
          if (!st_s2_q) sst_q <= PSC_S_IDLE;
        end
        default: sst_q <= PSC_S_IDLE;
      endcase
    end
  end

  // Fault qualification and retry
  function automatic logic [31:0] fdelay(input logic [1:0] code);
    case (code)
      2'd0:    fdelay = 32'(FDELAY0_CYC);
      2'd1:    fdelay = 32'(FDELAY1_CYC);
      2'd2:    fdelay = 32'(FDELAY2_CYC);
      default: fdelay = 32'(FDELAY3_CYC);
    endcase
  endfunction

  logic [1:0]  rcode;
  assign rcode = cfg_q[F_RETRY_LO +: 2];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fst_q        <= PSC_F_IDLE;
      flt_cnt_q    <= 32'h0;
      tries_q      <= 3'd0;
      rail_restart <= 1'b0;
    end else begin
      rail_restart <= 1'b0;
      case (fst_q)
        PSC_F_IDLE: begin
          flt_cnt_q <= 32'h0;
          if (flt_s2_q) fst_q <= PSC_F_QUAL;
        end
        PSC_F_QUAL: begin
          if (!flt_s2_q) begin
            fst_q <= PSC_F_IDLE;
          end else if (flt_cnt_q >= fdelay(cfg_q[F_FDELAY_LO +: 2]) - 32'h1) begin
            flt_cnt_q <= 32'h0;
            if (rcode == 2'd0 || (rcode != 2'd3 && tries_q >= RETRY_LIMIT)) begin
              fst_q <= PSC_F_STOP;
            end else begin
              fst_q <= PSC_F_WAIT;
            end
          end else begin
            flt_cnt_q <= flt_cnt_q + 32'h1;
          end
        end
        PSC_F_WAIT: begin
          if (flt_cnt_q >= ((rcode == 2'd1) ? 32'(RETRY_SHORT_CYC) : 32'(RETRY_LONG_CYC))
                           - 32'h1) begin
            rail_restart <= 1'b1;
            tries_q      <= (tries_q == 3'd7) ? tries_q : tries_q + 3'd1;
            fst_q        <= PSC_F_IDLE;
          end else begin
            flt_cnt_q <= flt_cnt_q + 32'h1;
          end
        end
        PSC_F_STOP: begin
          // Only reset or a write to the general configuration releases a latched shutdown
          if (wr && hit(paddr, IDX_GENERAL_CFG)) begin
            fst_q   <= PSC_F_IDLE;
            tries_q <= 3'd0;
          end
        end
        default: fst_q <= PSC_F_IDLE;
      endcase
    end
  end

  // Temperature source and common level
  logic [8:0]  room9;
  logic [7:0]  tsel;
  assign room9 = {room_q, dly_q[B_ROOM_LSB]};
  assign tsel  = cfg_q[B_INT_SENSOR] ? int_s2_q : ext_s2_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temp_used    <= 8'h0;
      common_level <= 9'h0;
    end else begin
      temp_used <= tsel;
      if (!dly_q[B_COMP_EN]) begin
        common_level <= room9;
      end else if (tsel <= lowbrk_q) begin
        common_level <= room9 + {4'h0, seql_q[4:0]};
      end else begin
        common_level <= room9 + {4'h0, hot1_q};
      end
    end
  end
endmodule

// >>> tb/psc_regs_checker.sv
// Checker for the panel supply register bank: bus handshake and pulse shapes.
// Assumes it is bound to psc_regs and sees only that module's ports.
`timescale 1ns/100ps
module psc_regs_checker (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Controls
  input wire logic        nv_reload_pulse,
  input wire logic        rail_restart,
  input wire logic [2:0]  startup_step
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Exactly one wait state: ready follows the first access edge
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_ready_cause: assert property (!(psel && penable) |=> !pready)
    else $error("ready without access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // Registers are at most 8 bits wide, so the upper word must stay clear
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reload_pulse: assert property (nv_reload_pulse |=> !nv_reload_pulse)
    else $error("reload pulse too long");
  a_restart_pulse: assert property (rail_restart |=> !rail_restart)
    else $error("restart pulse too long");
  a_step_range: assert property (startup_step <= 3'd3)
    else $error("start step out of range");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pslverr);
  c_done: cover property (startup_step == 3'd3);
endmodule

bind psc_regs psc_regs_checker i_chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .nv_reload_pulse(nv_reload_pulse),
  .rail_restart(rail_restart), .startup_step(startup_step));

// >>> tb/tb_psc_regs.sv
// Self-checking bench for the panel supply register bank over APB.
// Assumes the bound checker and a 25 MHz ref_clk; fault input raised only briefly, well below the qualification delay.
`timescale 1ns/100ps
module tb_psc_regs;
  import psc_pkg::*;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  ext_temp_code, int_temp_code, temp_used;
  logic        fault_raw, startup_req, nv_reload_pulse, switch_clk, rail_restart;
  logic [2:0]  startup_step, seq_order;
  logic [8:0]  common_level;
  int          errors;
  int          checks_done;
  logic [11:0] adr [6] = '{12'h01c, 12'h020, 12'h024, 12'h028, 12'h02c, 12'h038};
  logic [7:0]  rv [6]  = '{8'h04, 8'ha8, 8'h00, 8'h40, 8'h00, 8'h00};

  psc_regs i_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_temp_code(ext_temp_code),
    .int_temp_code(int_temp_code), .fault_raw(fault_raw), .startup_req(startup_req),
    .nv_reload_pulse(nv_reload_pulse), .switch_clk(switch_clk),
    .rail_restart(rail_restart), .startup_step(startup_step), .seq_order(seq_order),
    .common_level(common_level), .temp_used(temp_used));

  always #20 ref_clk = ~ref_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idles a cycle after release so psel is never driven twice in one step
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] er, input logic ee);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk(32'(pready), 32'h1);
    chk(32'(pslverr), 32'(ee));
    if (!w) chk(prdata, er);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic hi_lo(input logic v, inout int n);
    while (switch_clk !== v && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic period(output int n);
    n = 0;
    hi_lo(1'b0, n);
    hi_lo(1'b1, n);
    n = 0;
    hi_lo(1'b0, n);
    hi_lo(1'b1, n);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    close_out;
  end

  initial begin
    int n;
    ref_clk = 1'b0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; fault_raw = 1'b0; startup_req = 1'b0;
    ext_temp_code = 8'h40; int_temp_code = 8'h77; errors = 0; checks_done = 0;
    cyc(4);
    srst <= 1'b0;
    cyc(1);
    foreach (adr[i]) acc(1'b0, adr[i], 32'h0, 32'(rv[i]), 1'b0);
    acc(1'b1, 12'h040, 32'h5a, 32'h0, 1'b1);
    acc(1'b0, 12'h025, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 12'h02c, 32'hffffffff, 32'h0, 1'b0);
    acc(1'b0, 12'h02c, 32'h0, 32'h1f, 1'b0);
    acc(1'b1, 12'h038, 32'h20, 32'h0, 1'b0);
    acc(1'b0, 12'h038, 32'h0, 32'h20, 1'b0);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 12'h028, {24'h0, 3'(c), 5'h05}, 32'h0, 1'b0);
      cyc(3);
      chk(32'(seq_order), 32'(c));
    end
    acc(1'b1, 12'h024, 32'hd5, 32'h0, 1'b0);
    acc(1'b1, 12'h020, 32'h01, 32'h0, 1'b0);
    cyc(3);
    chk(32'(common_level), 32'h1ab);
    acc(1'b1, 12'h020, 32'h03, 32'h0, 1'b0);
    cyc(8);
    chk(32'(common_level), 32'h1ca);
    ext_temp_code <= 8'h10;
    cyc(8);
    chk(32'(common_level), 32'h1b0);
    chk(32'(temp_used), 32'h10);
    acc(1'b1, 12'h01c, 32'h84, 32'h0, 1'b0);
    cyc(8);
    chk(32'(temp_used), 32'h77);
    $display("test level done");
    acc(1'b1, 12'h01c, 32'h04, 32'h0, 1'b0);
    cyc(100);
    period(n);
    chk(32'(n), 32'd12);
    acc(1'b1, 12'h01c, 32'h14, 32'h0, 1'b0);
    cyc(150);
    period(n);
    chk(32'(n), 32'd60);
    $display("test rate done");
    startup_req <= 1'b1;
    for (n = 0; n < 30 && startup_step !== 3'd3; n++) @(posedge ref_clk);
    chk(32'(startup_step), 32'h3);
    fault_raw <= 1'b1;
    cyc(4);
    acc(1'b0, 12'h080, 32'h0, 32'h60, 1'b0);
    fault_raw <= 1'b0;
    cyc(4);
    acc(1'b0, 12'h080, 32'h0, 32'h20, 1'b0);
    chk(32'(rail_restart), 32'h0);
    srst        <= 1'b1;
    startup_req <= 1'b0;
    cyc(2);
    srst <= 1'b0;
    cyc(2);
    acc(1'b0, 12'h020, 32'h0, 32'ha8, 1'b0);
    startup_req <= 1'b1;
    cyc(1000);
    chk(32'(startup_step), 32'h0);
    chk(32'(nv_reload_pulse), 32'h0);
    $display("test start-up done");
    close_out;
  end
endmodule
